//--- inc/sudi_pkg.sv
// Package for the sensor units and device information register bank.
package sudi_pkg;
  // Register addresses (protocol addresses, zero based).
  localparam logic [15:0] ADDR_UNIT_SYSTEM = 16'h0190;
  localparam logic [15:0] ADDR_GAS_MIX = 16'h019d;
  localparam logic [15:0] ADDR_DEV_ID = 16'h01f4;
  localparam logic [15:0] ADDR_PRESENCE = 16'h01f5;
  localparam logic [15:0] ADDR_MB_HW = 16'h01f6;
  localparam logic [15:0] ADDR_MB_FW = 16'h01f7;
  localparam logic [15:0] ADDR_SM_HW = 16'h01f8;
  localparam logic [15:0] ADDR_SM_FW = 16'h01f9;
  localparam logic [15:0] ADDR_RSVD_A = 16'h01fa;
  localparam logic [15:0] ADDR_RSVD_B = 16'h01fb;
  localparam logic [15:0] ADDR_VOUT_MIN = 16'h01fc;
  localparam logic [15:0] ADDR_VOUT_MAX = 16'h01fd;
  localparam logic [15:0] ADDR_OP_HOURS = 16'h01fe;
  localparam logic [15:0] ADDR_MAINT_CD = 16'h01ff;
  localparam logic [15:0] ADDR_INSP_CD = 16'h0200;

  // Field values and limits.
  localparam logic [15:0] UNIT_METRIC = 16'h0001;
  localparam logic [15:0] UNIT_IMPERIAL = 16'h0002;
  localparam logic [15:0] GAS_MIX_MAX = 16'h0064;
  localparam logic [15:0] VOUT_MIN_MAX = 16'h0009;
  localparam logic [15:0] VOUT_FULL = 16'h000a;
  localparam logic [15:0] VOUT_HALF = 16'h0005;
  localparam int PRESENCE_BITS = 8;

  // Reset values.
  localparam logic [15:0] RST_UNIT = UNIT_METRIC;
  localparam logic [15:0] RST_GAS_MIX = 16'h0032;
  localparam logic [15:0] RST_VOUT_MIN = 16'h0000;
  localparam logic [15:0] RST_COUNTDOWN = 16'h4470;
  localparam logic [15:0] RST_OP_HOURS = 16'h0000;

  // Timing: one hour at 250 MHz.
  localparam longint HOUR_S = 3600;
  localparam longint CLK_HZ = 250000000;
  localparam longint HOUR_CYCLES = HOUR_S * CLK_HZ;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sudi_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } sudi_rsp_t;
endpackage

//--- rtl/sudi_hour_tick.sv
// Divider that yields a one-cycle pulse per elapsed operating hour.
module sudi_hour_tick #(
  parameter longint HOUR_CYCLES = 64'd900000000000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Tick
  output logic tick
);
  logic [39:0] cnt_q;
  wire logic at_end;
  wire logic [39:0] last;

  assign last = 40'(HOUR_CYCLES - 1);
  assign at_end = (cnt_q == last);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 40'h0;
      tick <= 1'b0;
    end
    else
    begin
      cnt_q <= at_end ? 40'h0 : cnt_q + 40'h1;
      tick <= at_end;
    end
  end
endmodule

//--- rtl/sudi_countdown.sv
// Service countdown that loses one per hour, stops at zero, reloads only by write.
module sudi_countdown
  import sudi_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic load,
  input wire logic [15:0] load_val,
  // State
  output logic [15:0] value,
  output logic expired
);
  logic [15:0] value_d;
  wire logic is_zero;

  assign is_zero = (value == 16'h0000);

  // A write wins over a tick in the same cycle, so the fresh value is not shortened.
  always_comb
  begin
    value_d = value;
    if (load)
      value_d = load_val;
    else if (tick && !is_zero)
      value_d = value - 16'h0001;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      value <= RST_COUNTDOWN;
      expired <= 1'b0;
    end
    else
    begin
      value <= value_d;
      expired <= (value_d == 16'h0000);
    end
  end

  property p_cd_stop;
    @(posedge clock) disable iff (!rst_n)
      (is_zero && !load) |=> is_zero;
  endproperty
  a_cd_stop: assert property (p_cd_stop)
    else $error("Countdown left zero without a write.");
endmodule

//--- rtl/sudi_regs.sv
// Register bank for unit selection, gas mix weight and device information.

module sudi_regs
  import sudi_pkg::*;
#(
  // The identification value is arbitrary.
  parameter logic [15:0] DEVICE_ID = 16'h0abc,
  parameter logic [7:0] MB_HW_MAJOR = 8'h01,
  parameter logic [7:0] MB_HW_MINOR = 8'h00,
  parameter logic [7:0] MB_FW_MAJOR = 8'h01,
  parameter logic [7:0] MB_FW_MINOR = 8'h00,
  parameter logic [7:0] SM_HW_MAJOR = 8'h01,
  parameter logic [7:0] SM_HW_MINOR = 8'h00,
  parameter logic [7:0] SM_FW_MAJOR = 8'h01,
  parameter logic [7:0] SM_FW_MINOR = 8'h00,
  parameter bit FLOW_VARIANT = 1'b0,
  parameter longint HOUR_CYCLES_P = HOUR_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register access from the protocol engine
  input wire sudi_pkg::sudi_req_t req,
  output sudi_pkg::sudi_rsp_t rsp,
  // Board state
  input wire logic dip_sw5,
  input wire logic dip_sw6,
  input wire logic [PRESENCE_BITS-1:0] sensor_present,
  input wire logic maint_symbol_en,
  input wire logic insp_symbol_en,
  // Settings and indications for the rest of the sensor
  output logic [15:0] unit_system,
  output logic [6:0] gas_mix_weight,
  output logic [3:0] vout_min,
  output logic [3:0] vout_max,
  output logic maint_symbol,
  output logic insp_symbol
);
  import sudi_pkg::*;

  logic [15:0] unit_q;
  logic [15:0] gas_q;
  logic [15:0] vmin_q;
  logic [15:0] hours_q;
  logic [15:0] presence_q;
  logic [15:0] rdata_d;
  wire logic hour_tick;
  wire logic [15:0] maint_val;
  wire logic [15:0] insp_val;
  wire logic maint_exp;
  wire logic insp_exp;
  wire logic [15:0] unit_eff;
  wire logic [15:0] vmax_val;
  wire logic hit_unit;
  wire logic hit_gas;
  wire logic hit_vmin;
  wire logic hit_maint;
  wire logic hit_insp;
  wire logic hit_ro;
  wire logic unit_ok;
  wire logic gas_ok;
  wire logic vmin_ok;
  wire logic wr_err;

  sudi_hour_tick #(
    .HOUR_CYCLES(HOUR_CYCLES_P)
  ) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .tick(hour_tick)
  );

  // Address decode.
  assign hit_unit = (req.addr == ADDR_UNIT_SYSTEM);
  assign hit_gas = (req.addr == ADDR_GAS_MIX);
  assign hit_vmin = (req.addr == ADDR_VOUT_MIN);
  assign hit_maint = (req.addr == ADDR_MAINT_CD);
  assign hit_insp = (req.addr == ADDR_INSP_CD);
  assign hit_ro = (req.addr >= ADDR_DEV_ID) && (req.addr <= ADDR_VOUT_MAX)
    && (req.addr != ADDR_VOUT_MIN) || (req.addr == ADDR_OP_HOURS);

  // Value checks: out-of-range writes are refused and leave the register alone.
  assign unit_ok = ((req.wdata == UNIT_METRIC) || (req.wdata == UNIT_IMPERIAL))
    && !FLOW_VARIANT;
  assign gas_ok = (req.wdata <= GAS_MIX_MAX);
  assign vmin_ok = (req.wdata <= VOUT_MIN_MAX);
  // Writes to read-only or reserved words are ignored and flagged.
  assign wr_err = (hit_unit && !unit_ok) || (hit_gas && !gas_ok)
    || (hit_vmin && !vmin_ok) || hit_ro;

  // In the flow variant the unit follows the sixth switch.
  assign unit_eff = FLOW_VARIANT ? (dip_sw6 ? UNIT_IMPERIAL : UNIT_METRIC) : unit_q;
  assign vmax_val = dip_sw5 ? VOUT_HALF : VOUT_FULL;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      unit_q <= RST_UNIT;
    else if (req.wr && hit_unit && unit_ok)
      unit_q <= req.wdata;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      gas_q <= RST_GAS_MIX;
    else if (req.wr && hit_gas && gas_ok)
      gas_q <= req.wdata;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      vmin_q <= RST_VOUT_MIN;
    else if (req.wr && hit_vmin && vmin_ok)
      vmin_q <= req.wdata;
  end

  // Operating hours saturate rather than wrap after about seven years.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      hours_q <= RST_OP_HOURS;
    else if (hour_tick && (hours_q != 16'hffff))
      hours_q <= hours_q + 16'h0001;
  end

  // Presence is registered so a read sees one stable snapshot.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      presence_q <= 16'h0000;
    else
      presence_q <= {8'h00, sensor_present};
  end

  // The device never reloads an expired countdown; only a master write does.
  sudi_countdown u_maint (
    .clock(clock),
    .rst_n(rst_n),
    .tick(hour_tick),
    .load(req.wr && hit_maint),
    .load_val(req.wdata),
    .value(maint_val),
    .expired(maint_exp)
  );

  sudi_countdown u_insp (
    .clock(clock),
    .rst_n(rst_n),
    .tick(hour_tick),
    .load(req.wr && hit_insp),
    .load_val(req.wdata),
    .value(insp_val),
    .expired(insp_exp)
  );

  // Read multiplexer; anything unmapped reads zero.
  always_comb
  begin
    rdata_d = 16'h0000;
    if (req.addr == ADDR_UNIT_SYSTEM)
      rdata_d = unit_eff;
    else if (req.addr == ADDR_GAS_MIX)
      rdata_d = gas_q;
    else if (req.addr == ADDR_DEV_ID)
      rdata_d = DEVICE_ID;
    else if (req.addr == ADDR_PRESENCE)
      rdata_d = presence_q;
    else if (req.addr == ADDR_MB_HW)
      rdata_d = {MB_HW_MAJOR, MB_HW_MINOR};
    else if (req.addr == ADDR_MB_FW)
      rdata_d = {MB_FW_MAJOR, MB_FW_MINOR};
    else if (req.addr == ADDR_SM_HW)
      rdata_d = {SM_HW_MAJOR, SM_HW_MINOR};
    else if (req.addr == ADDR_SM_FW)
      rdata_d = {SM_FW_MAJOR, SM_FW_MINOR};
    else if (req.addr == ADDR_VOUT_MIN)
      rdata_d = vmin_q;
    else if (req.addr == ADDR_VOUT_MAX)
      rdata_d = vmax_val;
    else if (req.addr == ADDR_OP_HOURS)
      rdata_d = hours_q;
    else if (req.addr == ADDR_MAINT_CD)
      rdata_d = maint_val;
    else if (req.addr == ADDR_INSP_CD)
      rdata_d = insp_val;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rsp <= '0;
    else
    begin
      rsp.ack <= req.rd || req.wr;
      rsp.err <= req.wr && wr_err;
      rsp.rdata <= req.rd ? rdata_d : 16'h0000;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unit_system <= RST_UNIT;
      gas_mix_weight <= 7'h00;
      vout_min <= 4'h0;
      vout_max <= 4'ha;
      maint_symbol <= 1'b0;
      insp_symbol <= 1'b0;
    end
    else
    begin
      unit_system <= unit_eff;
      gas_mix_weight <= gas_q[6:0];
      vout_min <= vmin_q[3:0];
      vout_max <= vmax_val[3:0];
      maint_symbol <= maint_exp && maint_symbol_en;
      insp_symbol <= insp_exp && insp_symbol_en;
    end
  end

  sequence s_rd_req(logic [15:0] a);
    req.rd && (req.addr == a);
  endsequence

  sequence s_wr_req(logic [15:0] a);
    req.wr && (req.addr == a);
  endsequence

  property p_unit_legal;
    @(posedge clock) disable iff (!rst_n)
      (unit_system == UNIT_METRIC) || (unit_system == UNIT_IMPERIAL);
  endproperty
  a_unit_legal: assert property (p_unit_legal)
    else $error("Unit system left its legal values.");

  property p_flow_unit;
    @(posedge clock) disable iff (!rst_n)
      FLOW_VARIANT |=> (unit_system == (($past(dip_sw6)) ? UNIT_IMPERIAL : UNIT_METRIC));
  endproperty
  a_flow_unit: assert property (p_flow_unit)
    else $error("Flow variant unit does not follow switch six.");

  property p_gas_range;
    @(posedge clock) disable iff (!rst_n)
      gas_q <= GAS_MIX_MAX;
  endproperty
  a_gas_range: assert property (p_gas_range)
    else $error("Gas mix weight above one hundred.");

  property p_presence_high;
    @(posedge clock) disable iff (!rst_n)
      s_rd_req(ADDR_PRESENCE) |=> (rsp.rdata[15:8] == 8'h00) && rsp.ack;
  endproperty
  a_presence_high: assert property (p_presence_high)
    else $error("Unassigned presence bits read nonzero.");

  property p_vmin_range;
    @(posedge clock) disable iff (!rst_n)
      vmin_q <= VOUT_MIN_MAX;
  endproperty
  a_vmin_range: assert property (p_vmin_range)
    else $error("Minimum output voltage above nine.");

  property p_vmax;
    @(posedge clock) disable iff (!rst_n)
      s_rd_req(ADDR_VOUT_MAX) |=> (rsp.rdata == ($past(dip_sw5) ? VOUT_HALF : VOUT_FULL));
  endproperty
  a_vmax: assert property (p_vmax)
    else $error("Maximum output voltage does not follow switch five.");

  property p_hours_tick;
    @(posedge clock) disable iff (!rst_n)
      (hour_tick && hours_q != 16'hffff) |=> (hours_q == $past(hours_q) + 16'h0001);
  endproperty
  a_hours_tick: assert property (p_hours_tick)
    else $error("Operating hours did not advance on the hour.");

  property p_rsvd_zero;
    @(posedge clock) disable iff (!rst_n)
      (s_rd_req(ADDR_RSVD_A) or s_rd_req(ADDR_RSVD_B)) |=> (rsp.rdata == 16'h0000);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Reserved word read nonzero.");

  property p_maint_sym;
    @(posedge clock) disable iff (!rst_n)
      (maint_exp && maint_symbol_en) |=> maint_symbol;
  endproperty
  a_maint_sym: assert property (p_maint_sym)
    else $error("Maintenance symbol missing after expiry.");

  property p_insp_sym;
    @(posedge clock) disable iff (!rst_n)
      (insp_exp && insp_symbol_en) |=> insp_symbol;
  endproperty
  a_insp_sym: assert property (p_insp_sym)
    else $error("Inspection symbol missing after expiry.");

  property p_ro_refused;
    @(posedge clock) disable iff (!rst_n)
      (req.wr && hit_ro) |=> (rsp.ack && rsp.err);
  endproperty
  a_ro_refused: assert property (p_ro_refused)
    else $error("Write to a read-only or reserved word was not refused.");

  property p_unit_refused;
    @(posedge clock) disable iff (!rst_n)
      (req.wr && hit_unit && !unit_ok) |=> $stable(unit_q);
  endproperty
  a_unit_refused: assert property (p_unit_refused)
    else $error("Refused unit write changed the unit register.");

  property p_gas_refused;
    @(posedge clock) disable iff (!rst_n)
      (req.wr && hit_gas && !gas_ok) |=> $stable(gas_q);
  endproperty
  a_gas_refused: assert property (p_gas_refused)
    else $error("Refused gas mix write changed the register.");

  property p_maint_load;
    @(posedge clock) disable iff (!rst_n)
      s_wr_req(ADDR_MAINT_CD) |=> (maint_val == $past(req.wdata));
  endproperty
  a_maint_load: assert property (p_maint_load)
    else $error("Maintenance countdown did not take the written value.");

  property p_insp_load;
    @(posedge clock) disable iff (!rst_n)
      s_wr_req(ADDR_INSP_CD) |=> (insp_val == $past(req.wdata));
  endproperty
  a_insp_load: assert property (p_insp_load)
    else $error("Inspection countdown did not take the written value.");
endmodule

//--- tb/sudi_master.sv
// Register bus master model that issues single word reads and writes.
module sudi_master
  import sudi_pkg::*;
(
  // Clock
  input wire logic clock,
  // Register access
  output sudi_pkg::sudi_req_t req,
  input wire sudi_pkg::sudi_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    req = '0;
  end

  // The strobe stands for one edge only, and the answer is taken in the cycle after it.
  // Address and data are inverted on release, so that a stale bus value cannot pass for a good one.
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                        output sudi_rsp_t r);
    @(negedge clock);
    req = '{wr: wr, rd: !wr, addr: addr, wdata: wr ? wdata : ~addr};
    @(negedge clock);
    r = rsp;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the unit selection and device information register bank.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sudi_pkg::*;

  // The identification value is arbitrary.
  localparam logic [15:0] DEV_ID = 16'h0c3d;
  localparam longint HOUR = 20;
  localparam logic [15:0] MB_HW_V = 16'h0406, MB_FW_V = 16'h0102, SM_HW_V = 16'h0201;
  localparam logic [15:0] SM_FW_V = 16'h0a0b;
  localparam bit FLOW_V = 1'b1;

  logic clock;
  logic rst_n;
  sudi_req_t req;
  sudi_rsp_t rsp;
  logic dip_sw5;
  logic dip_sw6;
  logic [7:0] sensor_present;
  logic maint_en;
  logic insp_en;
  logic [15:0] unit_system;
  logic [15:0] unit_flow;
  logic [6:0] gas_mix_weight;
  logic [3:0] vout_min;
  logic [3:0] vout_max;
  logic maint_symbol;
  logic insp_symbol;
  logic [15:0] lfsr_q = 16'h002e;
  logic [15:0] v;
  logic [15:0] a;
  int n_mismatch = 0;
  int n_tests = 0;

  sudi_master sudi_master_inst (.clock(clock), .req(req), .rsp(rsp));

  sudi_regs #(.DEVICE_ID(DEV_ID), .MB_HW_MAJOR(MB_HW_V[15:8]), .MB_HW_MINOR(MB_HW_V[7:0]),
    .MB_FW_MAJOR(MB_FW_V[15:8]), .MB_FW_MINOR(MB_FW_V[7:0]), .SM_HW_MAJOR(SM_HW_V[15:8]),
    .SM_HW_MINOR(SM_HW_V[7:0]), .SM_FW_MAJOR(SM_FW_V[15:8]), .SM_FW_MINOR(SM_FW_V[7:0]),
    .HOUR_CYCLES_P(HOUR)) sudi_regs_inst (.clock(clock), .rst_n(rst_n),
    .req(req), .rsp(rsp), .dip_sw5(dip_sw5), .dip_sw6(dip_sw6), .sensor_present(sensor_present),
    .maint_symbol_en(maint_en), .insp_symbol_en(insp_en), .unit_system(unit_system),
    .gas_mix_weight(gas_mix_weight), .vout_min(vout_min), .vout_max(vout_max),
    .maint_symbol(maint_symbol), .insp_symbol(insp_symbol));

  // The flow variant sees the same bus traffic but must ignore every unit write.
  sudi_regs #(.FLOW_VARIANT(FLOW_V), .HOUR_CYCLES_P(HOUR)) sudi_regs_flow_inst (.clock(clock),
    .rst_n(rst_n), .req(req), .rsp(), .dip_sw5(dip_sw5), .dip_sw6(dip_sw6),
    .sensor_present(sensor_present), .maint_symbol_en(maint_en), .insp_symbol_en(insp_en),
    .unit_system(unit_flow), .gas_mix_weight(), .vout_min(), .vout_max(), .maint_symbol(),
    .insp_symbol());

  always #2 clock = ~clock;

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  function automatic logic [15:0] exp_ro(input logic [15:0] addr);
    case (addr)
      ADDR_DEV_ID: return DEV_ID;
      ADDR_PRESENCE: return {8'h00, sensor_present};
      ADDR_MB_HW: return MB_HW_V;
      ADDR_MB_FW: return MB_FW_V;
      ADDR_SM_HW: return SM_HW_V;
      ADDR_SM_FW: return SM_FW_V;
      ADDR_VOUT_MAX: return dip_sw5 ? VOUT_HALF : VOUT_FULL;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    chk16({15'h0000, got}, {15'h0000, exp}, msg);
  endtask

  task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
    sudi_rsp_t r;
    sudi_master_inst.access(1'b0, addr, 16'h0000, r);
    chk1(r.ack, 1'b1, "read ack");
    chk16(r.rdata, exp, $sformatf("read %h", addr));
  endtask

  task automatic wr(input logic [15:0] addr, input logic [15:0] data, input logic err);
    sudi_rsp_t r;
    sudi_master_inst.access(1'b1, addr, data, r);
    chk1(r.ack, 1'b1, "write ack");
    chk1(r.err, err, $sformatf("write %h error flag", addr));
  endtask

  // Two reads whose taking edges are exactly five hours apart.
  task automatic delta5(input logic [15:0] addr, input logic up);
    sudi_rsp_t r;
    logic [15:0] h;
    sudi_master_inst.access(1'b0, addr, 16'h0000, r);
    h = r.rdata;
    repeat (5 * HOUR - 2) @(negedge clock);
    sudi_master_inst.access(1'b0, addr, 16'h0000, r);
    chk16(up ? r.rdata - h : h - r.rdata, 16'h0005, "hourly step");
  endtask

  task automatic finish_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    dip_sw5 = 1'b0;
    dip_sw6 = 1'b0;
    sensor_present = 8'h21;
    maint_en = 1'b1;
    insp_en = 1'b0;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    rd(ADDR_OP_HOURS, RST_OP_HOURS);
    rd(ADDR_MAINT_CD, 16'h4470);
    rd(ADDR_INSP_CD, 16'h4470);
    rd(ADDR_VOUT_MIN, 16'h0000);
    rd(ADDR_UNIT_SYSTEM, UNIT_METRIC);
    rd(ADDR_GAS_MIX, RST_GAS_MIX);
    for (int s = 0; s < 2; s++)
    begin
      dip_sw5 = s[0];
      dip_sw6 = s[0];
      sensor_present = s[0] ? 8'h20 : 8'(rnd());
      repeat (3) @(negedge clock);
      chk16({12'h000, vout_max}, s[0] ? VOUT_HALF : VOUT_FULL, "max volts port");
      chk16(unit_flow, s[0] ? UNIT_IMPERIAL : UNIT_METRIC, "flow unit port");
      for (int i = 0; i < 9; i++)
      begin
        a = ADDR_DEV_ID + 16'(i) + 16'(i == 8);
        wr(a, rnd(), 1'b1);
        rd(a, exp_ro(a));
      end
    end
    wr(16'h0300, 16'h5a5a, 1'b0);
    rd(16'h0300, 16'h0000);
    wr(ADDR_UNIT_SYSTEM, UNIT_IMPERIAL, 1'b0);
    wr(ADDR_UNIT_SYSTEM, 16'h0003, 1'b1);
    wr(ADDR_UNIT_SYSTEM, 16'h0000, 1'b1);
    rd(ADDR_UNIT_SYSTEM, UNIT_IMPERIAL);
    chk16(unit_system, UNIT_IMPERIAL, "unit port");
    wr(ADDR_UNIT_SYSTEM, UNIT_METRIC, 1'b0);
    @(negedge clock);
    chk16(unit_system, UNIT_METRIC, "unit port");
    chk16(unit_flow, UNIT_IMPERIAL, "flow unit after write");
    for (int i = 0; i < 10; i++)
    begin
      v = (i == 0) ? GAS_MIX_MAX : rnd() % 16'd101;
      wr(ADDR_GAS_MIX, v, 1'b0);
      wr(ADDR_GAS_MIX, GAS_MIX_MAX + 16'h0001 + rnd() % 16'd50, 1'b1);
      rd(ADDR_GAS_MIX, v);
      chk16({9'h000, gas_mix_weight}, v, "gas mix port");
      v = (i == 0) ? VOUT_MIN_MAX : rnd() % 16'd10;
      wr(ADDR_VOUT_MIN, v, 1'b0);
      wr(ADDR_VOUT_MIN, 16'h000a, 1'b1);
      rd(ADDR_VOUT_MIN, v);
      chk16({12'h000, vout_min}, v, "min volts port");
    end
    delta5(ADDR_OP_HOURS, 1'b1);
    wr(ADDR_MAINT_CD, 16'h0003, 1'b0);
    wr(ADDR_INSP_CD, 16'h0028, 1'b0);
    delta5(ADDR_INSP_CD, 1'b0);
    repeat (2 * HOUR) @(negedge clock);
    rd(ADDR_MAINT_CD, 16'h0000);
    chk1(maint_symbol, 1'b1, "maintenance symbol");
    wr(ADDR_INSP_CD, 16'h0000, 1'b0);
    repeat (2) @(negedge clock);
    chk1(insp_symbol, 1'b0, "inspection symbol disabled");
    insp_en = 1'b1;
    maint_en = 1'b0;
    repeat (3) @(negedge clock);
    chk1(insp_symbol, 1'b1, "inspection symbol");
    chk1(maint_symbol, 1'b0, "maintenance symbol disabled");
    maint_en = 1'b1;
    wr(ADDR_MAINT_CD, 16'h0064, 1'b0);
    repeat (2) @(negedge clock);
    chk1(maint_symbol, 1'b0, "maintenance symbol after restart");
    delta5(ADDR_MAINT_CD, 1'b0);
    // A second reset in mid-run must bring the written words back to their defaults.
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    rd(ADDR_MAINT_CD, RST_COUNTDOWN);
    rd(ADDR_GAS_MIX, RST_GAS_MIX);
    finish_test();
  end
endmodule
